// ===== hdl/gpp_defines.vh
// Register offsets, reset values and lock constants for the GPIO port block.
// Assumes an AHB-Lite slave with 32-bit data and a 4 KB window per port.
`ifndef GPP_DEFINES_VH
`define GPP_DEFINES_VH
`define GPP_OFF_DATA_LAST 12'h3fc
`define GPP_OFF_DIR 12'h400
`define GPP_OFF_IS 12'h404
`define GPP_OFF_IBE 12'h408
`define GPP_OFF_IEV 12'h40c
`define GPP_OFF_IM 12'h410
`define GPP_OFF_RIS 12'h414
`define GPP_OFF_MIS 12'h418
`define GPP_OFF_ICR 12'h41c
`define GPP_OFF_AFSEL 12'h420
`define GPP_OFF_DRL 12'h500
`define GPP_OFF_DRM 12'h504
`define GPP_OFF_DRH 12'h508
`define GPP_OFF_ODR 12'h50c
`define GPP_OFF_PUR 12'h510
`define GPP_OFF_PDR 12'h514
`define GPP_OFF_SLR 12'h518
`define GPP_OFF_DEN 12'h51c
`define GPP_OFF_LOCK 12'h520
`define GPP_OFF_COMMIT 12'h524
`define GPP_OFF_ID_FIRST 12'hfd0
`define GPP_RST_DRL 8'hff
`define GPP_RST_LOCK 32'h00000001
// Arbitrary key value; writing anything else relocks
`define GPP_UNLOCK_KEY 32'h00005a5a
`endif

// ===== hdl/gpp_port.v
// One GPIO port: data/direction, interrupt detection, ownership, lock/commit, pad control.
// Assumes a single AHB-Lite master; pin inputs arrive asynchronously from the pads.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "gpp_defines.vh"

// How it works
// - One port interrupt output while any pin has an enabled pending condition.
// - Edge events stay pending until software clears them.
// - Sense bit: 0 edge detection, 1 level detection.
// - Both-edges bit: 0 single edge per polarity, 1 both edges.
// - Polarity bit: 0 low or falling, 1 high or rising.
// - Mask bit: 0 blocks the pin, 1 forwards it.
// - Raw status readable regardless of mask.
// - Masked status shows only forwarded conditions.
// - Writing one to clear location clears that pin; zeros leave it.
// - Software should mask before changing sense, both-edges or polarity.
// - Alternate-function bit hands the pin to the peripheral.
// - Protected alternate-function writes need unlock and commit bits set.
// - Only debug pins are protected: port B pin 7, port C pins 3..0.
// - Pad settings: drive, open drain, pulls, slew, digital enable go to pad.
// - Non-debug pins reset undriven with select, enable and pulls zero.
// - Read-only identification words fixed at reset.
// - Alternate function ignores direction; peripheral pins need digital enable.
// - Direction 0 input captures pad; 1 output drives stored data.
// - Address bits 9..2 mask data accesses; masked bits unchanged or read zero.
module gpp_port #(
    parameter W = 8,
    parameter [W-1:0] DBG_PINS = 8'h00,
    parameter [31:0] ID_WORD0 = 32'h00000011,
    parameter [31:0] ID_WORD1 = 32'h00000022
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire [W-1:0] pin_in,
    output wire [W-1:0] pin_out,
    output wire [W-1:0] pin_oe,
    input wire [W-1:0] alt_out,
    input wire [W-1:0] alt_oe,
    output wire [W-1:0] alt_in,
    output wire [W-1:0] pad_drive_low,
    output wire [W-1:0] pad_drive_mid,
    output wire [W-1:0] pad_drive_high,
    output wire [W-1:0] pad_open_drain,
    output wire [W-1:0] pad_pull_up,
    output wire [W-1:0] pad_pull_down,
    output wire [W-1:0] pad_slew,
    output wire [W-1:0] pad_digital_en,
    output wire irq
);

    function [W-1:0] upd;
        input [W-1:0] old;
        input [31:0] nv;
        input [W-1:0] keep;
        begin
            upd = (old & keep) | (nv[W-1:0] & ~keep);
        end
    endfunction

    reg [W-1:0] pin_data_r, pin_direction_r, irq_sense_select_r, irq_both_edges_r;
    reg [W-1:0] irq_event_polarity_r, irq_mask_r, edge_pend_r, alt_function_select_r;
    reg [W-1:0] drive_low_select_r, drive_mid_select_r, drive_high_select_r;
    reg [W-1:0] open_drain_select_r, pull_up_select_r, pull_down_select_r;
    reg [W-1:0] slew_control_select_r, digital_pad_enable_r, config_commit_r;
    reg locked_r;
    reg [W-1:0] sync1_r, sync2_r, prev_r;
    reg wr_pend_r;
    reg [11:0] wr_addr_r;
    reg [W-1:0] wr_dmask_r;

    wire [11:0] a = haddr[11:0];
    wire take = hsel & hready & htrans[1];
    wire wr_data = wr_pend_r & (wr_addr_r <= `GPP_OFF_DATA_LAST);
    wire [W-1:0] wd = hwdata[W-1:0];

    // Pin reaches edge logic only after two flops
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= {W{1'b0}};
            sync2_r <= {W{1'b0}};
            prev_r <= {W{1'b0}};
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    wire [W-1:0] rise = sync2_r & ~prev_r;
    wire [W-1:0] fall = ~sync2_r & prev_r;
    wire [W-1:0] edge_hit = ~irq_sense_select_r &
        ((irq_both_edges_r & (rise | fall)) |
         (~irq_both_edges_r & ((irq_event_polarity_r & rise) | (~irq_event_polarity_r & fall))));
    wire [W-1:0] level_hit = irq_sense_select_r &
        ~(sync2_r ^ irq_event_polarity_r);
    wire [W-1:0] raw_status = (edge_pend_r & ~irq_sense_select_r) | level_hit;
    wire [W-1:0] masked_status = raw_status & irq_mask_r;
    assign irq = |masked_status;

    wire [W-1:0] clr = (wr_pend_r && wr_addr_r == `GPP_OFF_ICR) ? wd : {W{1'b0}};
    // Protected bits only move when unlocked and committed
    wire [W-1:0] af_keep = DBG_PINS & ~(config_commit_r & {W{~locked_r}});

    // Address phase registered, write data lands in data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            wr_dmask_r <= {W{1'b0}};
        end else begin
            wr_pend_r <= take & hwrite;
            wr_addr_r <= a;
            wr_dmask_r <= a[W+1:2];
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_data_r <= {W{1'b0}};
            pin_direction_r <= {W{1'b0}};
            irq_sense_select_r <= {W{1'b0}};
            irq_both_edges_r <= {W{1'b0}};
            irq_event_polarity_r <= {W{1'b0}};
            irq_mask_r <= {W{1'b0}};
            edge_pend_r <= {W{1'b0}};
            alt_function_select_r <= DBG_PINS;
            drive_low_select_r <= `GPP_RST_DRL;
            drive_mid_select_r <= {W{1'b0}};
            drive_high_select_r <= {W{1'b0}};
            open_drain_select_r <= {W{1'b0}};
            pull_up_select_r <= DBG_PINS;
            pull_down_select_r <= {W{1'b0}};
            slew_control_select_r <= {W{1'b0}};
            digital_pad_enable_r <= DBG_PINS;
            config_commit_r <= ~DBG_PINS;
            locked_r <= 1'b1;
        end else begin
            // Set beats a same-cycle clear; level pins never latch
            edge_pend_r <= ((edge_pend_r & ~clr) | edge_hit) & ~irq_sense_select_r;
            if (wr_data)
                pin_data_r <= upd(pin_data_r, hwdata, ~wr_dmask_r);
            if (wr_pend_r) begin
                case (wr_addr_r)
                    `GPP_OFF_DIR: pin_direction_r <= wd;
                    // Changing these while unmasked may fire a spurious edge
                    `GPP_OFF_IS: irq_sense_select_r <= wd;
                    `GPP_OFF_IBE: irq_both_edges_r <= wd;
                    `GPP_OFF_IEV: irq_event_polarity_r <= wd;
                    `GPP_OFF_IM: irq_mask_r <= wd;
                    `GPP_OFF_AFSEL: alt_function_select_r <= upd(alt_function_select_r, hwdata, af_keep);
                    `GPP_OFF_DRL: drive_low_select_r <= wd;
                    `GPP_OFF_DRM: drive_mid_select_r <= wd;
                    `GPP_OFF_DRH: drive_high_select_r <= wd;
                    `GPP_OFF_ODR: open_drain_select_r <= wd;
                    `GPP_OFF_PUR: pull_up_select_r <= wd;
                    `GPP_OFF_PDR: pull_down_select_r <= wd;
                    `GPP_OFF_SLR: slew_control_select_r <= wd;
                    `GPP_OFF_DEN: digital_pad_enable_r <= wd;
                    `GPP_OFF_LOCK: locked_r <= (hwdata != `GPP_UNLOCK_KEY);
                    // Commit bits exist only on protected pins
                    `GPP_OFF_COMMIT: if (!locked_r)
                        config_commit_r <= upd(config_commit_r, hwdata, ~DBG_PINS);
                    default: ;
                endcase
            end
        end
    end

    // Input value seen through the pad enable; output bits read back stored data
    wire [W-1:0] data_view = (pin_direction_r & pin_data_r) |
        (~pin_direction_r & sync2_r & digital_pad_enable_r);

    // Reads answer in the data phase from registered address
    reg rd_pend_r;
    reg [11:0] rd_addr_r;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_r <= 1'b0;
            rd_addr_r <= 12'h000;
        end else begin
            rd_pend_r <= take & ~hwrite;
            rd_addr_r <= a;
        end
    end

    reg [W-1:0] rv;
    always @* begin
        rv = {W{1'b0}};
        if (rd_addr_r <= `GPP_OFF_DATA_LAST)
            rv = data_view & rd_addr_r[W+1:2];
        else begin
            case (rd_addr_r)
                `GPP_OFF_DIR: rv = pin_direction_r;
                `GPP_OFF_IS: rv = irq_sense_select_r;
                `GPP_OFF_IBE: rv = irq_both_edges_r;
                `GPP_OFF_IEV: rv = irq_event_polarity_r;
                `GPP_OFF_IM: rv = irq_mask_r;
                `GPP_OFF_RIS: rv = raw_status;
                `GPP_OFF_MIS: rv = masked_status;
                `GPP_OFF_AFSEL: rv = alt_function_select_r;
                `GPP_OFF_DRL: rv = drive_low_select_r;
                `GPP_OFF_DRM: rv = drive_mid_select_r;
                `GPP_OFF_DRH: rv = drive_high_select_r;
                `GPP_OFF_ODR: rv = open_drain_select_r;
                `GPP_OFF_PUR: rv = pull_up_select_r;
                `GPP_OFF_PDR: rv = pull_down_select_r;
                `GPP_OFF_SLR: rv = slew_control_select_r;
                `GPP_OFF_DEN: rv = digital_pad_enable_r;
                `GPP_OFF_LOCK: rv = {{(W-1){1'b0}}, locked_r};
                `GPP_OFF_COMMIT: rv = config_commit_r;
                default: rv = {W{1'b0}};
            endcase
        end
    end

    // Data output is combinational on the data phase; ID words are constants
    always @* begin
        hrdata = 32'h00000000;
        if (rd_pend_r) begin
            if (rd_addr_r == `GPP_OFF_ID_FIRST)
                hrdata = ID_WORD0;
            else if (rd_addr_r == `GPP_OFF_ID_FIRST + 12'h004)
                hrdata = ID_WORD1;
            else
                hrdata = {{(32-W){1'b0}}, rv};
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Ownership mux: peripheral or software drives the pad
    assign pin_out = (alt_out & alt_function_select_r) | (pin_data_r & ~alt_function_select_r);
    assign pin_oe = digital_pad_enable_r &
        ((alt_function_select_r & alt_oe) | (~alt_function_select_r & pin_direction_r));
    assign alt_in = sync2_r & alt_function_select_r & digital_pad_enable_r;
    assign pad_drive_low = drive_low_select_r;
    assign pad_drive_mid = drive_mid_select_r;
    assign pad_drive_high = drive_high_select_r;
    assign pad_open_drain = open_drain_select_r;
    assign pad_pull_up = pull_up_select_r;
    assign pad_pull_down = pull_down_select_r;
    assign pad_slew = slew_control_select_r;
    assign pad_digital_en = digital_pad_enable_r;

endmodule

// ===== bench/gpp_port_chk.sv
// Checker for the GPIO port bus, pad and interrupt outputs.
// Assumes it is bound to gpp_port and sees only its ports.
`timescale 1ns/1ps
module gpp_port_chk #(
    parameter W = 8,
    parameter [W-1:0] DBG_PINS = 8'h00,
    parameter [31:0] ID_WORD0 = 32'h00000011
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire [W-1:0] pin_oe,
    input wire [W-1:0] alt_in,
    input wire [W-1:0] pad_drive_low,
    input wire [W-1:0] pad_pull_up,
    input wire [W-1:0] pad_pull_down,
    input wire [W-1:0] pad_digital_en,
    input wire irq
);
    reg rd_r;
    reg [11:0] addr_r;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Read data phase follows the address phase directly, no wait states
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_r <= 1'b0;
            addr_r <= 12'h000;
        end else begin
            rd_r <= hsel && hready && htrans[1] && !hwrite;
            addr_r <= haddr[11:0];
        end
    end
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus wait or error response");
    AST_RDATA_IDLE: assert property (!rd_r |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    AST_DATA_MASK: assert property (rd_r && addr_r < 12'h400 |-> (hrdata & ~{24'h0, addr_r[9:2]}) == 32'h0)
        else $error("data read ignores address mask");
    AST_ID_WORD: assert property (rd_r && addr_r == 12'hfd0 |-> hrdata == ID_WORD0)
        else $error("identification word wrong");
    AST_COMMIT_FIXED: assert property (rd_r && addr_r == 12'h524 |-> (hrdata[W-1:0] & ~DBG_PINS) == ~DBG_PINS)
        else $error("unprotected commit bit cleared");
    AST_MIS_IRQ: assert property (rd_r && addr_r == 12'h418 |-> irq == |hrdata[W-1:0])
        else $error("interrupt differs from masked status");
    AST_OE_DEN: assert property ((pin_oe & ~pad_digital_en) == {W{1'b0}})
        else $error("pin driven without digital enable");
    AST_ALTIN_DEN: assert property ((alt_in & ~pad_digital_en) == {W{1'b0}})
        else $error("peripheral input without digital enable");
    AST_RESET_PADS: assert property ($rose(hresetn) |-> pad_pull_down == 0 && pad_pull_up == DBG_PINS && pad_drive_low == {W{1'b1}})
        else $error("pad reset state wrong");
    cover property (rd_r && addr_r == 12'h418 && irq);
    cover property ($rose(irq));
    cover property (rd_r && addr_r == 12'h524);
endmodule

// ===== bench/gpp_pad_model.sv
// Model of the pads around one GPIO port.
// Assumes the bench sets the external drive levels.
`timescale 1ns/1ps
module gpp_pad_model #(
    parameter W = 8
) (
    input wire hclk,
    input wire [W-1:0] pin_out,
    input wire [W-1:0] pin_oe,
    input wire [W-1:0] pad_pull_up,
    input wire [W-1:0] pad_pull_down,
    input wire [W-1:0] ext_val,
    input wire [W-1:0] ext_en,
    output wire [W-1:0] pin_in
);
    logic [W-1:0] float_r = '0;
    // Undriven, unpulled pins wander so stale values never pass
    always @(posedge hclk) float_r <= ~float_r;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pad_pull_up | (~pad_pull_down & float_r)));
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for one GPIO port set up as the port with four debug pins.
// Assumes the pad model and checker are compiled first.
`timescale 1ns/1ps
`include "gpp_defines.vh"
module tb_top;
    localparam [7:0] DBG = 8'h0f;
    localparam [31:0] ID0 = 32'h000000a5; // Arbitrary value
    localparam [31:0] ID1 = 32'h0000005a; // Arbitrary value
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_pend = 0;
    logic [31:0] haddr = 0, hwdata = 0, seed = 32'd79683;
    logic [1:0] htrans = 0;
    logic [7:0] alt_out = 0, alt_oe = 0, ext_val = 0, ext_en = 0, stored, e;
    wire hreadyout, hresp, irq;
    wire [31:0] hrdata;
    wire [7:0] pin_in, pin_out, pin_oe, pu, pd;
    logic [65:0] exp_q[$];
    logic [65:0] ent;
    int errors = 0, num_checks = 0, cyc = 0;
    logic [11:0] ra[11] = '{12'h500, 12'h510, 12'h514, 12'h51c, 12'h420, 12'h400, 12'h520, 12'h524, 12'hfd0,
        12'hfd4, 12'h600};
    logic [31:0] rv[11] = '{32'hff, DBG, 0, DBG, DBG, 0, 1, {24'h0, ~DBG}, ID0, ID1, 0};
    // Per mode: cleared, after fall, after rise, polarity, both, sense
    logic [5:0] md[5] = '{6'b011100, 6'b010000, 6'b011010, 6'b001101, 6'b110001};
    always #4 hclk = ~hclk;
    gpp_port #(.DBG_PINS(DBG), .ID_WORD0(ID0), .ID_WORD1(ID1)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(), .pad_drive_low(),
        .pad_drive_mid(), .pad_drive_high(), .pad_open_drain(), .pad_pull_up(pu), .pad_pull_down(pd),
        .pad_slew(), .pad_digital_en(), .irq(irq));
    gpp_pad_model pads (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pad_pull_up(pu),
        .pad_pull_down(pd), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [65:0] x);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= wr;
        if (!wr) exp_q.push_back(x);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 66'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = 32'hffffffff,
        input logic [1:0] iq = 2'b00);
        xfer(1'b0, a, 32'h0, {iq, m, x});
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge hclk) rd_pend <= hsel && htrans[1] && !hwrite;
    always @(negedge hclk) begin
        if (rd_pend) begin
            ent = exp_q.pop_front();
            num_checks++;
            if (((hrdata ^ ent[31:0]) & ent[63:32]) !== 32'h0 || (ent[65] && irq !== ent[64])) begin
                errors++;
                $display("unexpected at %0t: read %h irq %b, want %h irq %b", $time, hrdata, irq, ent[31:0], ent[64]);
            end
        end
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            $display("unexpected at %0t: run hung", $time);
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        alt_oe <= rnd();
        alt_out <= rnd();
        @(posedge hclk);
        wr(12'h600, 32'hffffffff);
        for (int i = 0; i < 11; i++)
            rd(ra[i], rv[i]);
        wr(12'h420, 32'h0);
        rd(12'h420, {24'h0, DBG});
        wr(12'h524, 32'hff);
        rd(12'h524, {24'h0, ~DBG});
        wr(12'h520, `GPP_UNLOCK_KEY);
        rd(12'h520, 32'h0);
        wr(12'h524, 32'hff);
        rd(12'h524, 32'hff);
        wr(12'h420, 32'h0);
        rd(12'h420, 32'h0);
        wr(12'h520, 32'h0);
        rd(12'h520, 32'h1);
        wr(12'h51c, 32'hff);
        wr(12'h400, 32'hf0);
        stored = rnd();
        e = rnd();
        ext_en <= 8'hff;
        ext_val <= e;
        wr(12'h3fc, {24'h0, stored});
        wr(12'h0c0, {24'h0, ~stored});
        stored = stored ^ 8'h30;
        repeat (3) @(posedge hclk);
        rd(12'h3fc, {24'h0, stored[7:4], e[3:0]});
        rd(12'h0c4, {26'h0, stored[5:4], 3'h0, e[0]});
        wr(12'h404, 32'hff);
        wr(12'h40c, 32'hff);
        rd(12'h414, {24'h0, stored[7:4], 4'h0}, 32'hf0);
        wr(12'h420, 32'hf0);
        repeat (3) @(posedge hclk);
        rd(12'h414, {24'h0, ((alt_oe & alt_out) | (~alt_oe & e)) & 8'hf0}, 32'hf0);
        wr(12'h420, 32'h0);
        wr(12'h400, 32'h0);
        for (int m = 0; m < 5; m++) begin
            wr(12'h410, 32'h0);
            wr(12'h404, {31'h0, md[m][0]});
            wr(12'h408, {31'h0, md[m][1]});
            wr(12'h40c, {31'h0, md[m][2]});
            e = rnd();
            ext_val <= {e[7:1], 1'b0};
            repeat (4) @(posedge hclk);
            wr(12'h41c, 32'hff);
            wr(12'h410, 32'h1);
            ext_val[0] <= 1'b1;
            repeat (4) @(posedge hclk);
            rd(12'h414, {31'h0, md[m][3]}, 32'h1, {1'b1, md[m][3]});
            ext_val[0] <= 1'b0;
            repeat (4) @(posedge hclk);
            wr(12'h41c, 32'hfe);
            rd(12'h414, {31'h0, md[m][4]}, 32'h1, {1'b1, md[m][4]});
            wr(12'h41c, 32'h1);
            rd(12'h414, {31'h0, md[m][5]}, 32'h1, {1'b1, md[m][5]});
            wr(12'h410, 32'h0);
            rd(12'h418, 32'h0, 32'hff, 2'b10);
        end
        wrap_up();
    end
endmodule
bind gpp_port gpp_port_chk #(.W(W), .DBG_PINS(DBG_PINS), .ID_WORD0(ID_WORD0)) u_chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_oe(pin_oe), .alt_in(alt_in),
    .pad_drive_low(pad_drive_low), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
    .pad_digital_en(pad_digital_en), .irq(irq));
